// ---- hdl/oss_scheduler.sv ----
/*
 * Measurement scheduler of an optical proximity and ambient sensor:
 * wake-up timer, rate counters, overhead and conversion timing,
 * result registers and interrupt. Assumes a 40 MHz clock, inputs
 * synchronous to it, and a one-cycle strobe register port.
 */
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/10ps
// How it works
// - wake-up tick period equals base interval setting
// - prox/ambient periods are base times factor
// - zero prox factor means no prox activity
// - zero ambient factor suppresses vis, ir, aux
// - every tick costs 12.8 us active
// - prox period start adds 51.2 us overhead
// - ambient period start adds 51.2 us overhead
// - prox conversion is two gain-scaled phases
// - one conversion per enabled prox channel, own LED
// - visible conversion time from gain and recovery
// - infrared conversion time from gain and recovery
// - auxiliary conversion takes 61.5 us
// - recovery code selects ADC clock delay
// - gain code n scales integration by 2^n
// - standby whenever nothing is in progress
// - timing derived from internal system clock
// - result stored and interrupt raised per measurement
module oss_scheduler
    import oss_pkg::*;
#(
    parameter int TICK_CYC = oss_pkg::TICK_UNIT_CYC
) (
    // Clock and reset
    input wire logic SYS_CLK_I,
    input wire logic RESET_N_I,
    // Register port
    input wire logic [oss_pkg::ADDR_W-1:0] ADDR_I,
    input wire logic [oss_pkg::DATA_W-1:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [oss_pkg::DATA_W-1:0] RDATA_O,
    // Converter result
    input wire logic [oss_pkg::RES_W-1:0] ADC_RESULT_I,
    // Activity and LEDs
    output logic ACTIVE_O,
    output logic [oss_pkg::N_PROX-1:0] LED_O,
    // Interrupt
    output logic IRQ_O
);
    import oss_pkg::*;

    initial
    begin
        if (TICK_CYC < 1 || TICK_CYC > 2047)
            $error("oss_scheduler: TICK_CYC out of range");
    end

    typedef enum logic [2:0] {
        ST_STANDBY, ST_WAKE, ST_PROX_OVH, ST_PROX,
        ST_AMB_OVH, ST_VIS, ST_IR, ST_AUX
    } oss_state_t;

    // Software registers
    logic [CTRL_W-1:0] ctrl_q;
    logic [FACT_W-1:0] base_q;
    logic [FACT_W-1:0] prox_period_factor;
    logic [FACT_W-1:0] ambient_period_factor;
    logic [31:0] gain_q;
    logic [N_RES-1:0] irq_stat_q;
    logic [N_RES-1:0] irq_mask_q;
    logic [RES_W-1:0] data_q [N_RES];  // Result slots
    logic [DATA_W-1:0] rdata_q;

    // Scheduler state
    oss_state_t state_q, state_d;
    logic [1:0] chan_q, chan_d;         // Current prox channel
    logic phase_q, phase_d;             // Prox phase, two per channel
    logic run_q;                        // Previous run bit
    logic wake_pend_q;                  // Tick waiting for service
    logic prox_due_q, amb_due_q;        // Groups waiting for service
    logic active_q;
    logic [N_PROX-1:0] led_q;

    // Named fields
    wire run = ctrl_q[CTRL_RUN];
    wire [N_PROX-1:0] prox_en = ctrl_q[CTRL_PROX_EN +: N_PROX];
    wire vis_en = ctrl_q[CTRL_VIS_EN];
    wire ir_en = ctrl_q[CTRL_IR_EN];
    wire aux_en = ctrl_q[CTRL_AUX_EN];
    wire [2:0] prox_gain_code = gain_q[GAIN_PROX + FLD_GAIN +: 3];
    wire [2:0] prox_recovery_code = gain_q[GAIN_PROX + FLD_REC +: 3];
    wire [2:0] visible_gain_code = gain_q[GAIN_VIS + FLD_GAIN +: 3];
    wire [2:0] visible_recovery_code = gain_q[GAIN_VIS + FLD_REC +: 3];
    wire [2:0] infrared_gain_code = gain_q[GAIN_IR + FLD_GAIN +: 3];
    wire [2:0] infrared_recovery_code = gain_q[GAIN_IR + FLD_REC +: 3];

    // Register decode
    wire wr_ctrl = WR_I && (ADDR_I == OFS_CTRL);
    wire wr_base = WR_I && (ADDR_I == OFS_BASE);
    wire wr_rate = WR_I && (ADDR_I == OFS_RATE);
    wire wr_gain = WR_I && (ADDR_I == OFS_GAIN);
    wire wr_stat = WR_I && (ADDR_I == OFS_IRQ_STAT);
    wire wr_mask = WR_I && (ADDR_I == OFS_IRQ_MASK);
    wire [ADDR_W-1:0] data_ofs = ADDR_I - OFS_DATA0;
    wire [2:0] data_idx = data_ofs[4:2];
    wire data_hit = (ADDR_I >= OFS_DATA0) && (data_ofs[1:0] == 2'h0)
                    && (data_idx < 3'(N_RES)) && (data_ofs[7:5] == 3'h0);

    // Timing of the current step, scaled by gain and recovery
    wire [DUR_W-1:0] prox_base = DUR_W'(INTEG_CYC)
                                 + DUR_W'(rec_cycles(prox_recovery_code));
    wire [DUR_W-1:0] vis_base = DUR_W'(INTEG_CYC)
                                + DUR_W'(rec_cycles(visible_recovery_code));
    wire [DUR_W-1:0] ir_base = DUR_W'(INTEG_CYC)
                               + DUR_W'(rec_cycles(infrared_recovery_code));
    // Phase: 2 us plus (25.6 us + recovery) << gain
    wire [DUR_W-1:0] prox_dur = DUR_W'(PROX_FIX_CYC)
                                + (prox_base << prox_gain_code);
    // Twice the scaled term plus 4 us
    // Shift held at four bits so gain code 7 does not wrap to zero
    wire [3:0] vis_shift = 4'(visible_gain_code) + 4'h1;
    wire [3:0] ir_shift = 4'(infrared_gain_code) + 4'h1;
    wire [DUR_W-1:0] vis_dur = DUR_W'(AMB_FIX_CYC)
                               + (vis_base << vis_shift);
    // Same form for the infrared channel
    wire [DUR_W-1:0] ir_dur = DUR_W'(AMB_FIX_CYC)
                              + (ir_base << ir_shift);

    // Wake-up timer: base setting times the tick unit
    wire run_rise = run && !run_q;
    wire wake_done;
    wire [WAKE_W-1:0] wake_len = WAKE_W'(base_q) * WAKE_W'(TICK_CYC);
    wire wake_load = run_rise || wake_done || !run;
    wire tick = wake_done && run;
    // Zero length when stopped keeps the timer idle
    wire [WAKE_W-1:0] wake_val = run ? wake_len : '0;

    oss_down_timer #(.W(WAKE_W)) u_wake_timer (
        .clk_i(SYS_CLK_I),
        .rst_n_i(RESET_N_I),
        .load_i(wake_load),
        .value_i(wake_val),
        .done_o(wake_done)
    );

    // Rate counters advanced by each tick
    wire prox_due, amb_due;

    oss_rate_counter #(.W(FACT_W)) u_prox_rate (
        .clk_i(SYS_CLK_I),
        .rst_n_i(RESET_N_I),
        .start_i(run_rise),
        .tick_i(tick),
        .factor_i(prox_period_factor),
        .due_o(prox_due)
    );

    oss_rate_counter #(.W(FACT_W)) u_amb_rate (
        .clk_i(SYS_CLK_I),
        .rst_n_i(RESET_N_I),
        .start_i(run_rise),
        .tick_i(tick),
        .factor_i(ambient_period_factor),
        .due_o(amb_due)
    );

    // Step timer: loaded on every state entry or phase restart
    logic step;
    logic [DUR_W-1:0] dur_d;
    wire step_done;

    oss_down_timer #(.W(DUR_W)) u_step_timer (
        .clk_i(SYS_CLK_I),
        .rst_n_i(RESET_N_I),
        .load_i(step),
        .value_i(dur_d),
        .done_o(step_done)
    );

    // First enabled prox channel at or above a start index
    function automatic logic [2:0] next_chan(input logic [N_PROX-1:0] en,
                                             input logic [2:0] from);
        logic [2:0] found;
        found = 3'h7;
        for (int i = N_PROX - 1; i >= 0; i--)
            if (en[i] && 3'(i) >= from)
                found = 3'(i);
        return found;
    endfunction

    wire [2:0] first_chan = next_chan(prox_en, 3'h0);
    wire [2:0] later_chan = next_chan(prox_en, 3'(chan_q) + 3'h1);
    // Ambient channels only run inside an ambient period
    wire [2:0] amb_first = vis_en ? 3'h1 : ir_en ? 3'h2 : aux_en ? 3'h3
                           : 3'h0;

    // Result capture at the end of each conversion
    logic store;
    logic [2:0] store_idx;

    // Next state, step length and result capture
    always_comb
    begin
        state_d = state_q;
        chan_d = chan_q;
        phase_d = phase_q;
        step = 1'b0;
        dur_d = '0;
        store = 1'b0;
        store_idx = 3'h0;
        case (state_q)
            // Leave standby only for a pending tick
            ST_STANDBY:
                if (wake_pend_q && run)
                    state_d = ST_WAKE;
            // Counter advance done; pick the due group
            ST_WAKE:
                if (step_done)
                    state_d = prox_due_q ? ST_PROX_OVH
                              : amb_due_q ? ST_AMB_OVH : ST_STANDBY;
            // Prox period overhead, then channels in order
            ST_PROX_OVH:
                if (step_done)
                begin
                    if (first_chan != 3'h7)
                    begin
                        state_d = ST_PROX;
                        chan_d = first_chan[1:0];
                        phase_d = 1'b0;
                    end
                    else
                        state_d = amb_due_q ? ST_AMB_OVH : ST_STANDBY;
                end
            // Two phases per channel, result after the second
            ST_PROX:
                if (step_done)
                begin
                    if (!phase_q)
                    begin
                        phase_d = 1'b1;
                        step = 1'b1;  // Restart for phase two
                        dur_d = prox_dur;
                    end
                    else
                    begin
                        store = 1'b1;
                        store_idx = 3'(chan_q);
                        phase_d = 1'b0;
                        if (later_chan != 3'h7)
                        begin
                            chan_d = later_chan[1:0];
                            step = 1'b1;
                            dur_d = prox_dur;
                        end
                        else
                            state_d = amb_due_q ? ST_AMB_OVH : ST_STANDBY;
                    end
                end
            // Ambient period overhead covers vis, ir and aux
            ST_AMB_OVH:
                if (step_done)
                    case (amb_first)
                        3'h1: state_d = ST_VIS;
                        3'h2: state_d = ST_IR;
                        3'h3: state_d = ST_AUX;
                        default: state_d = ST_STANDBY;
                    endcase
            ST_VIS:
                if (step_done)
                begin
                    store = 1'b1;
                    store_idx = 3'(SLOT_VIS);
                    state_d = ir_en ? ST_IR : aux_en ? ST_AUX : ST_STANDBY;
                end
            ST_IR:
                if (step_done)
                begin
                    store = 1'b1;
                    store_idx = 3'(SLOT_IR);
                    state_d = aux_en ? ST_AUX : ST_STANDBY;
                end
            ST_AUX:
                if (step_done)
                begin
                    store = 1'b1;
                    store_idx = 3'(SLOT_AUX);
                    state_d = ST_STANDBY;
                end
            default:
                state_d = ST_STANDBY;
        endcase
        // Length of the state being entered
        if (state_d != state_q)
        begin
            step = 1'b1;
            case (state_d)
                ST_WAKE: dur_d = DUR_W'(WAKE_OVH_CYC);
                ST_PROX_OVH: dur_d = DUR_W'(GRP_OVH_CYC);
                ST_AMB_OVH: dur_d = DUR_W'(GRP_OVH_CYC);
                ST_PROX: dur_d = prox_dur;
                ST_VIS: dur_d = vis_dur;
                ST_IR: dur_d = ir_dur;
                ST_AUX: dur_d = DUR_W'(AUX_CYC);
                default: dur_d = '0;
            endcase
        end
    end

    // Interrupt events, one bit per result slot
    wire [N_RES-1:0] evt = store ? (N_RES'(1) << store_idx) : '0;

    // State, channel and activity flops
    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            state_q <= ST_STANDBY;
            chan_q <= 2'h0;
            phase_q <= 1'b0;
            active_q <= 1'b0;
            led_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            chan_q <= chan_d;
            phase_q <= phase_d;
            active_q <= (state_d != ST_STANDBY);
            // Each channel lights its own LED
            led_q <= (state_d == ST_PROX) ? (N_PROX'(1) << chan_d) : '0;
        end
    end

    // Pending tick and due groups; a new event wins over the clear
    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            run_q <= 1'b0;
            wake_pend_q <= 1'b0;
            prox_due_q <= 1'b0;
            amb_due_q <= 1'b0;
        end
        else
        begin
            run_q <= run;
            wake_pend_q <= run && (tick ||
                           (wake_pend_q && state_d != ST_WAKE));
            prox_due_q <= run && (prox_due ||
                          (prox_due_q && state_d != ST_PROX_OVH));
            amb_due_q <= run && (amb_due ||
                         (amb_due_q && state_d != ST_AMB_OVH));
        end
    end

    // Configuration registers
    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            ctrl_q <= '0;
            base_q <= '0;
            prox_period_factor <= '0;
            ambient_period_factor <= '0;
            gain_q <= RST_ZERO;
            irq_mask_q <= '0;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_q <= WDATA_I[CTRL_W-1:0];
            if (wr_base)
                base_q <= WDATA_I[FACT_W-1:0];
            if (wr_rate)
            begin
                prox_period_factor <= WDATA_I[FACT_W-1:0];
                ambient_period_factor <= WDATA_I[2*FACT_W-1:FACT_W];
            end
            // Codes are taken as written; host picks recovery
            if (wr_gain)
                gain_q <= WDATA_I;
            if (wr_mask)
                irq_mask_q <= WDATA_I[N_RES-1:0];
        end
    end

    // Sticky status, write one to clear, set wins
    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
            irq_stat_q <= '0;
        else
            irq_stat_q <= evt |
                          (irq_stat_q & ~(wr_stat ? WDATA_I[N_RES-1:0] : '0));
    end

    // Result slots
    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            for (int i = 0; i < N_RES; i++)
                data_q[i] <= '0;
        end
        else if (store)
            data_q[store_idx] <= ADC_RESULT_I;
    end

    // Read mux; unmapped addresses read zero
    logic [DATA_W-1:0] rd_mux;
    always_comb
    begin
        rd_mux = '0;
        case (ADDR_I)
            OFS_CTRL: rd_mux = DATA_W'(ctrl_q);
            OFS_BASE: rd_mux = DATA_W'(base_q);
            OFS_RATE: rd_mux = {ambient_period_factor, prox_period_factor};
            OFS_GAIN: rd_mux = gain_q;
            OFS_IRQ_STAT: rd_mux = DATA_W'(irq_stat_q);
            OFS_IRQ_MASK: rd_mux = DATA_W'(irq_mask_q);
            OFS_STATUS: rd_mux = DATA_W'({amb_due_q, prox_due_q,
                                          wake_pend_q, active_q});
            default:
                if (data_hit)
                    rd_mux = DATA_W'(data_q[data_idx]);
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
            rdata_q <= '0;
        else
            rdata_q <= RD_I ? rd_mux : '0;
    end

    assign RDATA_O = rdata_q;
    assign ACTIVE_O = active_q;
    assign LED_O = led_q;
    // Level interrupt from unmasked sticky bits
    assign IRQ_O = |(irq_stat_q & irq_mask_q);
endmodule

// ---- inc/oss_pkg.sv ----
/*
 * Shared constants of the optical sensor measurement scheduler:
 * register offsets, field positions, timing figures and helpers.
 * Assumes a 40 MHz system clock and 32-bit register words.
 */
package oss_pkg;

    // Clock period in ns at 40 MHz
    localparam int CLK_NS = 25;

    // Timing figures, ns as printed
    localparam int WAKE_OVH_NS = 12800;  // Rate counter advance
    localparam int GRP_OVH_NS = 51200;   // Per period start overhead
    localparam int PROX_FIX_NS = 2000;   // Fixed part of a prox phase
    localparam int AMB_FIX_NS = 4000;    // Fixed part of a visible/ir conv
    localparam int INTEG_NS = 25600;     // Base integration time
    localparam int AUX_NS = 61500;       // Auxiliary conversion
    localparam int ADC_CLK_NS = 50;      // ADC clock of the 20 MHz core
    localparam int REC_MIN_NS = 6400;    // Code 000 recovery time
    localparam int TICK_UNIT_NS = 31250; // Base interval unit (1/32000 s)

    // Cycle counts, least times rounded up
    localparam int WAKE_OVH_CYC = (WAKE_OVH_NS + CLK_NS - 1) / CLK_NS;
    localparam int GRP_OVH_CYC = (GRP_OVH_NS + CLK_NS - 1) / CLK_NS;
    localparam int PROX_FIX_CYC = (PROX_FIX_NS + CLK_NS - 1) / CLK_NS;
    localparam int AMB_FIX_CYC = (AMB_FIX_NS + CLK_NS - 1) / CLK_NS;
    localparam int INTEG_CYC = (INTEG_NS + CLK_NS - 1) / CLK_NS;
    localparam int AUX_CYC = (AUX_NS + CLK_NS - 1) / CLK_NS;
    localparam int ADC_CLK_CYC = (ADC_CLK_NS + CLK_NS - 1) / CLK_NS;
    localparam int REC_MIN_CYC = (REC_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int TICK_UNIT_CYC = (TICK_UNIT_NS + CLK_NS - 1) / CLK_NS;

    // Widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int RES_W = 16;
    localparam int FACT_W = 16;
    localparam int DUR_W = 21;
    localparam int WAKE_W = 28;
    localparam int N_PROX = 3;
    localparam int N_RES = 6;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_BASE = 8'h04;
    localparam logic [7:0] OFS_RATE = 8'h08;
    localparam logic [7:0] OFS_GAIN = 8'h0c;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_DATA0 = 8'h20;

    // Control fields
    localparam int CTRL_RUN = 0;
    localparam int CTRL_PROX_EN = 1;     // Three bits, one per channel
    localparam int CTRL_VIS_EN = 4;
    localparam int CTRL_IR_EN = 5;
    localparam int CTRL_AUX_EN = 6;
    localparam int CTRL_W = 7;

    // Gain register fields, one byte per channel group
    localparam int GAIN_PROX = 0;
    localparam int GAIN_VIS = 8;
    localparam int GAIN_IR = 16;
    localparam int FLD_GAIN = 0;         // Three bits
    localparam int FLD_REC = 3;          // Three bits
    localparam int FLD_RANGE = 6;

    // Result slots and interrupt bits share this layout
    localparam int SLOT_VIS = 3;
    localparam int SLOT_IR = 4;
    localparam int SLOT_AUX = 5;

    // Reset values
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;

    // Recovery delay in system clocks for a 3-bit code
    function automatic logic [11:0] rec_cycles(input logic [2:0] code);
        logic [11:0] adc_clks;
        adc_clks = (12'h004 << code) - 12'h001;
        if (code == 3'h0)
            return 12'(REC_MIN_CYC);
        return 12'(adc_clks * 12'(ADC_CLK_CYC));
    endfunction

endpackage

// ---- hdl/oss_down_timer.sv ----
/*
 * Reloadable down-counter: pulses done after the loaded number
 * of cycles. Assumes one clock and an active-low async reset.
 */
`timescale 1ns/10ps
module oss_down_timer #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Control
    input wire logic load_i,
    input wire logic [W-1:0] value_i,
    // Expiry
    output logic done_o
);
    initial
    begin
        if (W < 2)
            $error("oss_down_timer: W too small");
    end

    logic [W-1:0] cnt_q; // Cycles left, zero when idle

    // Last cycle of the loaded span; zero load never expires.
    // Kept free of load_i: callers reload from done_o itself,
    // so a path back through load_i would loop on itself.
    assign done_o = (cnt_q == W'(1));

    // Count down, load has priority
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            cnt_q <= '0;
        else if (load_i)
            cnt_q <= value_i;
        else if (cnt_q != '0)
            cnt_q <= cnt_q - W'(1);
    end
endmodule

// ---- hdl/oss_rate_counter.sv ----
/*
 * Period factor counter advanced by wake-up ticks; signals a due
 * measurement group. Assumes ticks are one-cycle pulses.
 */
`timescale 1ns/10ps
module oss_rate_counter #(
    parameter int W = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Control
    input wire logic start_i,
    input wire logic tick_i,
    input wire logic [W-1:0] factor_i,
    // Group due pulse
    output logic due_o
);
    initial
    begin
        if (W < 1)
            $error("oss_rate_counter: W too small");
    end

    logic [W-1:0] cnt_q; // Ticks left in the current period
    logic expire;        // Counter at its last tick

    // A zero factor never fires, so no group and no overhead
    assign expire = (cnt_q <= W'(1)) && (factor_i != '0);
    assign due_o = tick_i && expire && !start_i;

    // Decrement per tick, reload from the factor on expiry
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            cnt_q <= '0;
        else if (start_i)
            cnt_q <= factor_i;
        else if (tick_i)
            cnt_q <= expire ? factor_i : cnt_q - W'(1);
    end
endmodule

// ---- tb/oss_chk_assertions.sv ----
/* Port checker of the scheduler, bound into oss_scheduler.
   Assumes one clock and one-cycle register strobes. */
`timescale 1ns/10ps
module oss_chk (
    // Clock and reset
    input wire logic SYS_CLK_I,
    input wire logic RESET_N_I,
    // Watched ports
    input wire logic [7:0] ADDR_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [31:0] RDATA_O,
    input wire logic ACTIVE_O,
    input wire logic [2:0] LED_O,
    input wire logic IRQ_O
);
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (!RESET_N_I);
    // Length of the current active burst
    logic [15:0] run_q;
    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
        if (!RESET_N_I)
            run_q <= 16'h0;
        else
            run_q <= ACTIVE_O ? run_q + 16'h1 : 16'h0;
    led_one_hot_a: assert property ($onehot0(LED_O))
        else $error("several leds lit");
    led_needs_active_a: assert property (|LED_O |-> ACTIVE_O)
        else $error("led lit in standby");
    rdata_idle_a: assert property (!$past(RD_I) |-> RDATA_O == 32'h0)
        else $error("read data outside answer cycle");
    rdata_upper_a: assert property ($past(RD_I) && $past(ADDR_I) >= 8'h20
        |-> RDATA_O[31:16] == 16'h0)
        else $error("result upper half not zero");
    wake_len_a: assert property ($fell(ACTIVE_O) |-> run_q >= 16'h1fd)
        else $error("active burst too short");
    led_late_a: assert property ($rose(|LED_O) |-> run_q >= 16'h9c4)
        else $error("led before overheads");
    led_hold_a: assert property ($rose(|LED_O) |=> $stable(LED_O)[*7])
        else $error("led phase cut short");
    irq_fall_a: assert property ($fell(IRQ_O) |-> $past(WR_I))
        else $error("interrupt dropped without write");
endmodule
bind oss_scheduler oss_chk i_oss_chk (.SYS_CLK_I(SYS_CLK_I),
    .RESET_N_I(RESET_N_I), .ADDR_I(ADDR_I), .WR_I(WR_I), .RD_I(RD_I),
    .RDATA_O(RDATA_O), .ACTIVE_O(ACTIVE_O), .LED_O(LED_O), .IRQ_O(IRQ_O));

// ---- tb/oss_host.sv ----
/* Host model driving the register port of the scheduler.
   Assumes read data stand only in the cycle after the strobe. */
`timescale 1ns/10ps
module oss_host (
    // Clock
    input wire logic clk_i,
    // Register port
    output logic [7:0] addr_o = 8'h0,
    output logic [31:0] wdata_o = 32'h0,
    output logic wr_o = 1'b0,
    output logic rd_o = 1'b0,
    input wire logic [31:0] rdata_i
);
    // One-cycle write; data inverted once released
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        wdata_o <= ~d;
        #1;
    endtask
    // One-cycle read; answer taken once settled
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        #1;
        d = rdata_i;
    endtask
endmodule

// ---- tb/tb_top.sv ----
/* Self-checking bench of the scheduler with a host model.
   Assumes oss_pkg and a base unit cut to 4 cycles. */
`timescale 1ns/10ps
module tb_top;
    import oss_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr;
    logic [31:0] wdata, rdata;
    logic wr, rd, act, irq;
    logic [2:0] led;
    logic [15:0] adc = 16'h1234;
    int bad_count = 0;
    int n_checks = 0;
    int cyc = 0;
    int nw = 0;
    always #12.5 clk = ~clk;
    // Hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 99000)
        begin
            bad_count++;
            print_verdict();
        end
    end
    oss_scheduler #(.TICK_CYC(4)) i_oss_scheduler (.SYS_CLK_I(clk),
        .RESET_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
        .RD_I(rd), .RDATA_O(rdata), .ADC_RESULT_I(adc), .ACTIVE_O(act),
        .LED_O(led), .IRQ_O(irq));
    oss_host i_oss_host (.clk_i(clk), .addr_o(addr), .wdata_o(wdata),
        .wr_o(wr), .rd_o(rd), .rdata_i(rdata));
    task automatic print_verdict();
        if (bad_count == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Compare, allowing s cycles of slack on durations
    task automatic chk(input logic [31:0] got, exp, input int s);
        n_checks++;
        if (got === exp || (got + s >= exp && got <= exp + s))
            return;
        bad_count++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        i_oss_host.rd(a, d);
        chk(d, e, 0);
    endtask
    // Start, time one burst, stop again
    task automatic burst(input logic [31:0] c, output logic [31:0] na, nl);
        i_oss_host.wr(OFS_CTRL, c);
        na = 0;
        nl = 0;
        nw = 0;
        // Outputs are looked at on the falling edge, where they stand
        while (act !== 1'b1)
        begin
            @(negedge clk);
            nw++;
        end
        while (act === 1'b1)
        begin
            @(negedge clk);
            na++;
            nl += 32'(led[0] === 1'b1);
        end
        i_oss_host.wr(OFS_CTRL, 32'h0);
    endtask
    initial
    begin
        logic [31:0] na, nl, e;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rchk(OFS_CTRL, 32'h0);
        rchk(8'h3c, 32'h0);
        chk(32'({act, led, irq}), 32'h0, 0);
        i_oss_host.wr(OFS_BASE, 32'h3e8);
        burst(32'h3, na, nl);
        chk(nw, 32'h3e8 * 4, 3);
        chk(na, WAKE_OVH_CYC, 0);
        chk(nl, 32'h0, 0);
        i_oss_host.wr(OFS_BASE, 32'hdac);
        i_oss_host.wr(OFS_RATE, 32'h1);
        i_oss_host.wr(OFS_IRQ_MASK, 32'h1);
        for (int i = 0; i < 2; i++)
        begin
            // Recovery programmed as the gain's complement
            i_oss_host.wr(OFS_GAIN, i ? 32'h2a : 32'h38);
            burst(32'h3, na, nl);
            e = 2 * (PROX_FIX_CYC + ((INTEG_CYC + (i ? 254 : 1022)) << 2 * i));
            chk(nl, e, 0);
            chk(na, WAKE_OVH_CYC + GRP_OVH_CYC + e, 0);
            chk({31'h0, irq}, 32'h1, 0);
            rchk(OFS_DATA0, 32'h1234);
            i_oss_host.wr(OFS_IRQ_STAT, 32'h1);
            chk({31'h0, irq}, 32'h0, 0);
        end
        i_oss_host.wr(OFS_IRQ_MASK, 32'h0);
        i_oss_host.wr(OFS_RATE, 32'h1_0000);
        i_oss_host.wr(OFS_GAIN, 32'h41_4000);
        // New converter value tells the ambient slots from the prox slot
        @(posedge clk) adc <= 16'h5678;
        burst(32'h71, na, nl);
        e = 2 * AMB_FIX_CYC + 6 * (INTEG_CYC + REC_MIN_CYC) + AUX_CYC;
        chk(na, WAKE_OVH_CYC + GRP_OVH_CYC + e, 0);
        rchk(OFS_IRQ_STAT, 32'h38);
        chk({31'h0, irq}, 32'h0, 0);
        i_oss_host.wr(OFS_IRQ_MASK, 32'h38);
        chk({31'h0, irq}, 32'h1, 0);
        rchk(8'h2c, 32'h5678);
        rchk(OFS_DATA0, 32'h1234);
        i_oss_host.wr(OFS_IRQ_STAT, 32'h38);
        chk({31'h0, irq}, 32'h0, 0);
        print_verdict();
    end
endmodule
